// [card_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Behavioural card seated in one slot.
// ----------------------------------------
module card_model (
  // Clock and test controls.
  input wire logic       clk,
  input wire logic       insert,
  input wire logic [1:0] bat,
  input wire logic       ack_en,
  input wire logic       req,
  // Socket strobe seen by the card.
  input wire logic       rd_b,
  // Card pins.
  output logic           bat_one,
  output logic           bat_two,
  output logic           pres_one_b,
  output logic           pres_two_b,
  output logic           ack_b
);
  logic ack_d; // Acknowledge lags the read strobe by one cycle.

  always_ff @(posedge clk) begin
    ack_d <= ack_en && !rd_b;
  end
  // lines pulled high when no card is seated.
  assign bat_one = insert ? bat[0] : 1'b1;
  assign bat_two = insert ? bat[1] : 1'b1;
  // ready not modelled; this card is never busy.
  assign pres_one_b = !insert;
  assign pres_two_b = !insert;
  // request held low on the acknowledge line
  assign ack_b = !(insert && (req || ack_d));
endmodule

`default_nettype wire

// [card_socket_ctl.sv]
// Operation
// - both battery inputs high means good.
// - two low, one high means weak.
// - input one low means dead battery.
// - audio bit valid only in I/O mode.
// - merge slot audio onto one output.
// - card present when both detects low.
// - even and odd byte selects.
// - read strobe during host I/O reads.
// - read strobe for DMA to host.
// - write strobe low for I/O writes.
// - write strobe for DMA to card.
// - attribute select is DMA acknowledge.
`timescale 1ns/10ps
`default_nettype none
`include "socket_map.svh"

// Control and status signals for two card slots.
// Each slot has a status decoder and a cycle sequencer. The host side
// starts cycles through plain level ports, and every pin and status
// output is registered in this module. The block holds no registers
// that software reaches; all status is shown as live levels.
module card_socket_ctl (
  // Clock, reset and enable.
  input  wire logic       CORE_CLK,
  input  wire logic       RST_B,
  input  wire logic       CLK_EN,
  // Host command port for slot A.
  input  wire logic       A_START,
  input  wire logic [2:0] A_KIND,
  input  wire logic       A_ODD_ADDR,
  input  wire logic       A_WIDE,
  input  wire logic       A_IO_MODE,
  // Host command port for slot B.
  input  wire logic       B_START,
  input  wire logic [2:0] B_KIND,
  input  wire logic       B_ODD_ADDR,
  input  wire logic       B_WIDE,
  input  wire logic       B_IO_MODE,
  // Card pins for slot A.
  input  wire logic       A_BATTERY_DETECT_ONE,
  input  wire logic       A_BATTERY_DETECT_TWO,
  input  wire logic       A_CARD_PRESENT_ONE_B,
  input  wire logic       A_CARD_PRESENT_TWO_B,
  input  wire logic       A_IO_READ_ACK_B,
  output logic            A_EVEN_BYTE_SELECT_B,
  output logic            A_ODD_BYTE_SELECT_B,
  output logic            A_IO_READ_STROBE_B,
  output logic            A_IO_WRITE_STROBE_B,
  output logic            A_DMA_GRANT_ACK_B,
  // Card pins for slot B.
  input  wire logic       B_BATTERY_DETECT_ONE,
  input  wire logic       B_BATTERY_DETECT_TWO,
  input  wire logic       B_CARD_PRESENT_ONE_B,
  input  wire logic       B_CARD_PRESENT_TWO_B,
  input  wire logic       B_IO_READ_ACK_B,
  output logic            B_EVEN_BYTE_SELECT_B,
  output logic            B_ODD_BYTE_SELECT_B,
  output logic            B_IO_READ_STROBE_B,
  output logic            B_IO_WRITE_STROBE_B,
  output logic            B_DMA_GRANT_ACK_B,
  // Shared audio output.
  output logic            COMBINED_AUDIO_OUT,
  // Slot A status to the host.
  output logic            A_PRESENT,
  output logic [1:0]      A_BATTERY,
  output logic            A_CARD_STATUS_CHANGE,
  output logic            A_DMA_REQ,
  output logic            A_READ_ACKED,
  output logic            A_BUSY,
  output logic            A_DONE,
  // Slot B status to the host.
  output logic            B_PRESENT,
  output logic [1:0]      B_BATTERY,
  output logic            B_CARD_STATUS_CHANGE,
  output logic            B_DMA_REQ,
  output logic            B_READ_ACKED,
  output logic            B_BUSY,
  output logic            B_DONE
);

  // ------------------------------------------------------------
  // Slot decoders
  // ------------------------------------------------------------

  // Each decoder registers its slot's pins once and the output stage
  // adds a second register, so a pin change reaches the decoded status outputs
  // two enabled edges later. Both stages freeze while the clock enable
  // is low, so a slow host never sees a half-updated status.
  slot_status_if st_a ();  // Decoded status of slot A.
  slot_status_if st_b ();  // Decoded status of slot B.

  // Decoder for slot A pins.
  slot_decode u_dec_a (
    .clk           (CORE_CLK),
    .rst_b         (RST_B),
    .ce            (CLK_EN),
    .io_mode       (A_IO_MODE),
    .bat_one       (A_BATTERY_DETECT_ONE),
    .bat_two       (A_BATTERY_DETECT_TWO),
    .present_one_b (A_CARD_PRESENT_ONE_B),
    .present_two_b (A_CARD_PRESENT_TWO_B),
    .ack_b         (A_IO_READ_ACK_B),
    .st            (st_a.producer)
  );

  // Decoder for slot B pins.
  slot_decode u_dec_b (
    .clk           (CORE_CLK),
    .rst_b         (RST_B),
    .ce            (CLK_EN),
    .io_mode       (B_IO_MODE),
    .bat_one       (B_BATTERY_DETECT_ONE),
    .bat_two       (B_BATTERY_DETECT_TWO),
    .present_one_b (B_CARD_PRESENT_ONE_B),
    .present_two_b (B_CARD_PRESENT_TWO_B),
    .ack_b         (B_IO_READ_ACK_B),
    .st            (st_b.producer)
  );

  // ------------------------------------------------------------
  // Cycle sequencers
  // ------------------------------------------------------------

  // The sequencers count the strobe width themselves. The selects and
  // the DMA grant span setup, strobe and hold, so the card sees stable
  // selects on both edges of the strobe.
  logic rd_a;    // Slot A read strobe, high true.
  logic wr_a;    // Slot A write strobe, high true.
  logic ev_a;    // Slot A even select, high true.
  logic od_a;    // Slot A odd select, high true.
  logic dk_a;    // Slot A DMA grant, high true.
  logic busy_a;  // Slot A cycle in progress.
  logic done_a;  // Slot A end of cycle pulse.
  logic rd_b;    // Slot B read strobe, high true.
  logic wr_b;    // Slot B write strobe, high true.
  logic ev_b;    // Slot B even select, high true.
  logic od_b;    // Slot B odd select, high true.
  logic dk_b;    // Slot B DMA grant, high true.
  logic busy_b;  // Slot B cycle in progress.
  logic done_b;  // Slot B end of cycle pulse.
  logic go_a;    // Start slot A.
  logic go_b;    // Start slot B.

  // A cycle is only launched into a seated card, so a host request
  // into an empty socket never raises a strobe. The presence used is
  // the decoder's registered copy; a card pulled in mid-cycle still
  // finishes the cycle it was given.
  // start needs a card.
  assign go_a = A_START & st_a.present;
  assign go_b = B_START & st_b.present;

  // Sequencer for slot A.
  strobe_seq u_seq_a (
    .clk      (CORE_CLK),
    .rst_b    (RST_B),
    .ce       (CLK_EN),
    .start    (go_a),
    .kind     (A_KIND),
    .odd_addr (A_ODD_ADDR),
    .wide     (A_WIDE),
    .rd_on    (rd_a),
    .wr_on    (wr_a),
    .even_on  (ev_a),
    .odd_on   (od_a),
    .dma_grant_ack_on  (dk_a),
    .busy     (busy_a),
    .done     (done_a)
  );

  // Sequencer for slot B.
  strobe_seq u_seq_b (
    .clk      (CORE_CLK),
    .rst_b    (RST_B),
    .ce       (CLK_EN),
    .start    (go_b),
    .kind     (B_KIND),
    .odd_addr (B_ODD_ADDR),
    .wide     (B_WIDE),
    .rd_on    (rd_b),
    .wr_on    (wr_b),
    .even_on  (ev_b),
    .odd_on   (od_b),
    .dma_grant_ack_on  (dk_b),
    .busy     (busy_b),
    .done     (done_b)
  );

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------

  // Packs one slot's high-true strobes into its low-true pin image,
  // in the order of the concatenation in the output register.
  function automatic logic [4:0] pin_image(input logic ev,
                                           input logic od,
                                           input logic rd,
                                           input logic wr,
                                           input logic dk);
    pin_image = ~{ev, od, rd, wr, dk};
  endfunction

  // Next read acknowledge: caught while the strobe is on, then held.
  function automatic logic read_acked(input logic rd,
                                      input logic ack_b,
                                      input logic held,
                                      input logic busy);
    read_acked = (rd & ~ack_b) | (held & busy);
  endfunction

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------

  // The read acknowledge is held until the sequencer goes idle, so the
  // host can still see it after the strobe has ended. A card that never
  // answers leaves it low, which marks a read with no responder.
  logic [4:0] pins_a_next;               // Slot A active-low pin image.
  logic [4:0] pins_b_next;               // Slot B active-low pin image.
  logic       audio_next;                // Merged audio.
  logic       racked_a_next;             // Slot A read acknowledged.
  logic       racked_b_next;             // Slot B read acknowledged.

  // Compute the next pin and status values.
  always_comb begin
    pins_a_next = pin_image(ev_a, od_a, rd_a, wr_a, dk_a);
    pins_b_next = pin_image(ev_b, od_b, rd_b, wr_b, dk_b);
    // merge both slots' audio.
    // Exclusive-or keeps one slot's tone audible while the other idles.
    audio_next  = st_a.audio ^ st_b.audio;
    racked_a_next = read_acked(rd_a, A_IO_READ_ACK_B, A_READ_ACKED, busy_a);
    racked_b_next = read_acked(rd_b, B_IO_READ_ACK_B, B_READ_ACKED, busy_b);
  end

  // Register every output; pins idle deasserted after reset.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      // Card pins of both slots idle deasserted.
      {A_EVEN_BYTE_SELECT_B, A_ODD_BYTE_SELECT_B, A_IO_READ_STROBE_B,
       A_IO_WRITE_STROBE_B, A_DMA_GRANT_ACK_B} <= `PINS_IDLE;
      {B_EVEN_BYTE_SELECT_B, B_ODD_BYTE_SELECT_B, B_IO_READ_STROBE_B,
       B_IO_WRITE_STROBE_B, B_DMA_GRANT_ACK_B} <= `PINS_IDLE;
      // Shared audio starts silent.
      COMBINED_AUDIO_OUT   <= 1'b0;
      // Slot A status starts clear.
      A_PRESENT            <= 1'b0;
      A_BATTERY            <= `BATT_GOOD;
      A_CARD_STATUS_CHANGE <= 1'b0;
      A_DMA_REQ            <= 1'b0;
      A_READ_ACKED         <= 1'b0;
      A_BUSY               <= 1'b0;
      A_DONE               <= 1'b0;
      // Slot B status starts clear.
      B_PRESENT            <= 1'b0;
      B_BATTERY            <= `BATT_GOOD;
      B_CARD_STATUS_CHANGE <= 1'b0;
      B_DMA_REQ            <= 1'b0;
      B_READ_ACKED         <= 1'b0;
      B_BUSY               <= 1'b0;
      B_DONE               <= 1'b0;
    end else if (CLK_EN) begin
      // Card pins follow the sequencers.
      {A_EVEN_BYTE_SELECT_B, A_ODD_BYTE_SELECT_B, A_IO_READ_STROBE_B,
       A_IO_WRITE_STROBE_B, A_DMA_GRANT_ACK_B} <= pins_a_next;
      {B_EVEN_BYTE_SELECT_B, B_ODD_BYTE_SELECT_B, B_IO_READ_STROBE_B,
       B_IO_WRITE_STROBE_B, B_DMA_GRANT_ACK_B} <= pins_b_next;
      // Shared audio.
      COMBINED_AUDIO_OUT   <= audio_next;
      // Slot A status to the host.
      A_PRESENT            <= st_a.present;
      A_BATTERY            <= st_a.battery;
      A_CARD_STATUS_CHANGE <= st_a.status_change;
      A_DMA_REQ            <= st_a.dma_req;
      A_READ_ACKED         <= racked_a_next;
      A_BUSY               <= busy_a;
      A_DONE               <= done_a;
      // Slot B status to the host.
      B_PRESENT            <= st_b.present;
      B_BATTERY            <= st_b.battery;
      B_CARD_STATUS_CHANGE <= st_b.status_change;
      B_DMA_REQ            <= st_b.dma_req;
      B_READ_ACKED         <= racked_b_next;
      B_BUSY               <= busy_b;
      B_DONE               <= done_b;
    end
  end

endmodule

`default_nettype wire

// [slot_decode.sv]
`timescale 1ns/10ps
`default_nettype none
`include "socket_map.svh"

// Decodes the raw status pins of one slot into clean status.
module slot_decode (
  // Clock and control.
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic io_mode,
  // Card pins.
  input  wire logic bat_one,
  input  wire logic bat_two,
  input  wire logic present_one_b,
  input  wire logic present_two_b,
  input  wire logic ack_b,
  // Decoded status.
  slot_status_if.producer st
);

  // Registered copies of the decoded status.
  logic       present_reg, present_next;
  logic [1:0] batt_reg, batt_next;
  logic       chg_reg, chg_next;
  logic       aud_reg, aud_next;
  logic       dreq_reg, dreq_next;

  // Next status values from the pins.
  always_comb begin
    present_next = ~present_one_b & ~present_two_b;
    if (!bat_one) begin
      batt_next = `BATT_DEAD;
    end else if (!bat_two) begin
      batt_next = `BATT_WEAK;
    end else begin
      batt_next = `BATT_GOOD;
    end
    // Status change and ring are low-true on input one in I/O mode.
    chg_next = io_mode & present_next & ~bat_one;
    aud_next = io_mode & present_next & bat_two;
    dreq_next = present_next & (~ack_b | (io_mode & ~bat_two));
  end

  // Register the status while enabled.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      present_reg <= 1'b0;
      batt_reg    <= `BATT_GOOD;
      chg_reg     <= 1'b0;
      aud_reg     <= 1'b0;
      dreq_reg    <= 1'b0;
    end else if (ce) begin
      present_reg <= present_next;
      batt_reg    <= batt_next;
      chg_reg     <= chg_next;
      aud_reg     <= aud_next;
      dreq_reg    <= dreq_next;
    end
  end

  // Drive the status bundle.
  assign st.present       = present_reg;
  assign st.battery       = batt_reg;
  assign st.status_change = chg_reg;
  assign st.audio         = aud_reg;
  assign st.dma_req       = dreq_reg;

endmodule

`default_nettype wire

// [slot_status_if.sv]
`timescale 1ns/10ps
`default_nettype none

// Decoded status of one slot passed from the decoder to the top.
interface slot_status_if;
  logic       present;       // Card seated.
  logic [1:0] battery;       // Battery condition code.
  logic       status_change; // Status change or ring, active.
  logic       audio;         // Audio bit, valid in I/O mode.
  logic       dma_req;       // DMA request from the card.
  modport producer (output present, battery, status_change, audio, dma_req);
  modport consumer (input present, battery, status_change, audio, dma_req);
endinterface

`default_nettype wire

// [socket_map.svh]
`ifndef SOCKET_MAP_SVH
`define SOCKET_MAP_SVH

// Width of a status filter history.
`define FILT_LEN        2
// Battery condition encodings.
`define BATT_GOOD       2'h0
`define BATT_WEAK       2'h1
`define BATT_DEAD       2'h2
// Cycle kinds on the host command port.
`define CYC_NONE        3'h0
`define CYC_IO_RD       3'h1
`define CYC_IO_WR       3'h2
`define CYC_DMA_RD      3'h3
`define CYC_DMA_WR      3'h4
// Strobe width in clock cycles at 250 MHz (ns over period).
`define STROBE_NS       8'h50
`define CLK_NS          8'h04
`define STROBE_CYC      (`STROBE_NS / `CLK_NS)
// Width of the strobe counter.
`define CNT_W           8
// Idle image of a slot's five low-true card pins.
`define PINS_IDLE       5'h1f

`endif

// [socket_monitor.sv]
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Checker on the top ports of the socket.
// ----------------------------------------
module socket_monitor (
  // Clock, reset and enable.
  input wire logic       CORE_CLK,
  input wire logic       RST_B,
  input wire logic       CLK_EN,
  // Slot A card pins in.
  input wire logic       A_IO_MODE,
  input wire logic       A_BATTERY_DETECT_ONE,
  input wire logic       A_BATTERY_DETECT_TWO,
  input wire logic       A_CARD_PRESENT_ONE_B,
  input wire logic       A_CARD_PRESENT_TWO_B,
  // Slot A outputs.
  input wire logic       A_EVEN_BYTE_SELECT_B,
  input wire logic       A_ODD_BYTE_SELECT_B,
  input wire logic       A_IO_READ_STROBE_B,
  input wire logic       A_IO_WRITE_STROBE_B,
  input wire logic       A_DMA_GRANT_ACK_B,
  input wire logic       A_PRESENT,
  input wire logic [1:0] A_BATTERY,
  input wire logic       A_BUSY,
  input wire logic       A_DONE,
  // Slot B outputs.
  input wire logic       B_IO_READ_STROBE_B,
  input wire logic       B_IO_WRITE_STROBE_B,
  input wire logic       B_BUSY
);
  // All checks run on the core clock and sleep in reset or freeze.
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B || !CLK_EN);

  idle_quiet_a: assert property (!A_BUSY |-> A_IO_READ_STROBE_B &&
    A_IO_WRITE_STROBE_B && A_EVEN_BYTE_SELECT_B && A_ODD_BYTE_SELECT_B
    && A_DMA_GRANT_ACK_B) else $error("slot A pin active while idle");
  rw_excl_a: assert property (A_IO_READ_STROBE_B ||
    A_IO_WRITE_STROBE_B) else $error("slot A read and write together");
  dma_grant_ack_busy_a: assert property (!A_DMA_GRANT_ACK_B |-> A_BUSY)
    else $error("slot A grant outside a cycle");
  rd_width_a: assert property ($fell(A_IO_READ_STROBE_B) |->
    !A_IO_READ_STROBE_B[*8] ##13 $rose(A_IO_READ_STROBE_B))
    else $error("slot A read strobe width wrong");
  wr_width_a: assert property ($fell(A_IO_WRITE_STROBE_B) |->
    !A_IO_WRITE_STROBE_B[*8] ##13 $rose(A_IO_WRITE_STROBE_B))
    else $error("slot A write strobe width wrong");
  done_pulse_a: assert property ($fell(A_BUSY) |-> A_DONE ##1 !A_DONE)
    else $error("slot A done pulse wrong");
  batt_code_a: assert property ($past(RST_B) && $past(RST_B, 2) &&
    !$past(A_IO_MODE, 2) |-> A_BATTERY == (!$past(A_BATTERY_DETECT_ONE, 2)
    ? 2'h2 : (!$past(A_BATTERY_DETECT_TWO, 2) ? 2'h1 : 2'h0)))
    else $error("slot A battery code wrong");
  card_seen_a: assert property ($past(RST_B) && $past(RST_B, 2) |->
    A_PRESENT == (!$past(A_CARD_PRESENT_ONE_B, 2) &&
    !$past(A_CARD_PRESENT_TWO_B, 2))) else $error("slot A presence wrong");
  b_strobe_excl_a: assert property (B_IO_READ_STROBE_B ||
    B_IO_WRITE_STROBE_B || !B_BUSY) else $error("slot B strobes clash");
endmodule

bind card_socket_ctl socket_monitor u_mon (.*);

`default_nettype wire

// [socket_pkg.sv]
package socket_pkg;

  // Decoded battery condition of a memory card.
  typedef enum logic [1:0] {
    BATT_GOOD_S = 2'h0,
    BATT_WEAK_S = 2'h1,
    BATT_DEAD_S = 2'h2
  } batt_t;

  // Strobe sequencer states, Gray coded along the path.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_SETUP  = 2'h1,
    ST_STROBE = 2'h3,
    ST_HOLD   = 2'h2
  } cyc_state_t;

endpackage

// [strobe_seq.sv]
`timescale 1ns/10ps
`default_nettype none
`include "socket_map.svh"

// Sequences one I/O or DMA cycle on a slot: setup, strobe, hold.
module strobe_seq (
  // Clock and control.
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  // Request.
  input  wire logic       start,
  input  wire logic [2:0] kind,
  input  wire logic       odd_addr,
  input  wire logic       wide,
  // Strobes, high means asserted.
  output logic            rd_on,
  output logic            wr_on,
  output logic            even_on,
  output logic            odd_on,
  output logic            dma_grant_ack_on,
  output logic            busy,
  output logic            done
);

  socket_pkg::cyc_state_t     state_reg, state_next;
  logic [2:0]                 kind_reg, kind_next;
  logic                       odd_reg, odd_next;
  logic                       wide_reg, wide_next;
  logic [`CNT_W-1:0]          cnt_reg, cnt_next;
  logic                       done_next;

  // Next state of the sequencer.
  always_comb begin
    state_next = state_reg;
    kind_next  = kind_reg;
    odd_next   = odd_reg;
    wide_next  = wide_reg;
    cnt_next   = cnt_reg;
    done_next  = 1'b0;
    unique case (state_reg)
      socket_pkg::ST_IDLE: begin
        if (start && kind != `CYC_NONE) begin
          kind_next  = kind;
          odd_next   = odd_addr;
          wide_next  = wide;
          state_next = socket_pkg::ST_SETUP;
        end
      end
      socket_pkg::ST_SETUP: begin
        cnt_next   = `CNT_W'(`STROBE_CYC - 1);
        state_next = socket_pkg::ST_STROBE;
      end
      socket_pkg::ST_STROBE: begin
        if (cnt_reg == '0) begin
          state_next = socket_pkg::ST_HOLD;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      socket_pkg::ST_HOLD: begin
        done_next  = 1'b1;
        state_next = socket_pkg::ST_IDLE;
      end
    endcase
  end

  // Register the sequencer.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= socket_pkg::ST_IDLE;
      kind_reg  <= `CYC_NONE;
      odd_reg   <= 1'b0;
      wide_reg  <= 1'b0;
      cnt_reg   <= '0;
      done      <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      kind_reg  <= kind_next;
      odd_reg   <= odd_next;
      wide_reg  <= wide_next;
      cnt_reg   <= cnt_next;
      done      <= done_next;
    end
  end

  // Strobes follow the state; selects span the whole cycle.
  always_comb begin
    busy    = state_reg != socket_pkg::ST_IDLE;
    // read strobe for DMA to host.
    rd_on   = state_reg == socket_pkg::ST_STROBE &&
              (kind_reg == `CYC_IO_RD || kind_reg == `CYC_DMA_WR);
    // write strobe for DMA to card.
    wr_on   = state_reg == socket_pkg::ST_STROBE &&
              (kind_reg == `CYC_IO_WR || kind_reg == `CYC_DMA_RD);
    even_on = busy && (wide_reg || !odd_reg);
    odd_on  = busy && (wide_reg || odd_reg);
    dma_grant_ack_on = busy && (kind_reg == `CYC_DMA_RD || kind_reg == `CYC_DMA_WR);
  end

endmodule

`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Self-checking bench for both slots.
// ----------------------------------------
module testbench;
  logic       clk, rst_b, ce;      // Clock, reset, enable.
  logic [1:0] st, od, wd, io, ins, ae, rq; // Per-slot controls.
  logic [2:0] kd [2];              // Cycle kind per slot.
  logic [1:0] bt [2];              // Battery pins per slot.
  logic [1:0] b1, b2, c1, c2, ak;  // Card pins.
  logic [1:0] ev, ob, rd, wr, dk, pr, sc, dq, ra, bz, dn; // Outputs.
  logic [1:0] ba [2];              // Battery codes.
  logic       au;                  // Merged audio.
  int         fails, compares;     // Tallies.

  card_socket_ctl uut (.CORE_CLK(clk), .RST_B(rst_b), .CLK_EN(ce),
    .A_START(st[0]), .A_KIND(kd[0]), .A_ODD_ADDR(od[0]), .A_WIDE(wd[0]),
    .A_IO_MODE(io[0]), .B_START(st[1]), .B_KIND(kd[1]),
    .B_ODD_ADDR(od[1]), .B_WIDE(wd[1]), .B_IO_MODE(io[1]),
    .A_BATTERY_DETECT_ONE(b1[0]), .A_BATTERY_DETECT_TWO(b2[0]),
    .A_CARD_PRESENT_ONE_B(c1[0]), .A_CARD_PRESENT_TWO_B(c2[0]),
    .A_IO_READ_ACK_B(ak[0]), .A_EVEN_BYTE_SELECT_B(ev[0]),
    .A_ODD_BYTE_SELECT_B(ob[0]), .A_IO_READ_STROBE_B(rd[0]),
    .A_IO_WRITE_STROBE_B(wr[0]), .A_DMA_GRANT_ACK_B(dk[0]),
    .B_BATTERY_DETECT_ONE(b1[1]), .B_BATTERY_DETECT_TWO(b2[1]),
    .B_CARD_PRESENT_ONE_B(c1[1]), .B_CARD_PRESENT_TWO_B(c2[1]),
    .B_IO_READ_ACK_B(ak[1]), .B_EVEN_BYTE_SELECT_B(ev[1]),
    .B_ODD_BYTE_SELECT_B(ob[1]), .B_IO_READ_STROBE_B(rd[1]),
    .B_IO_WRITE_STROBE_B(wr[1]), .B_DMA_GRANT_ACK_B(dk[1]),
    .COMBINED_AUDIO_OUT(au), .A_PRESENT(pr[0]), .A_BATTERY(ba[0]),
    .A_CARD_STATUS_CHANGE(sc[0]), .A_DMA_REQ(dq[0]),
    .A_READ_ACKED(ra[0]), .A_BUSY(bz[0]), .A_DONE(dn[0]),
    .B_PRESENT(pr[1]), .B_BATTERY(ba[1]), .B_CARD_STATUS_CHANGE(sc[1]),
    .B_DMA_REQ(dq[1]), .B_READ_ACKED(ra[1]), .B_BUSY(bz[1]),
    .B_DONE(dn[1]));

  // One card model per slot.
  for (genvar i = 0; i < 2; i++) begin : g_card
    card_model u_card (.clk(clk), .insert(ins[i]), .bat(bt[i]),
      .ack_en(ae[i]), .req(rq[i]), .rd_b(rd[i]), .bat_one(b1[i]),
      .bat_two(b2[i]), .pres_one_b(c1[i]), .pres_two_b(c2[i]),
      .ack_b(ak[i]));
  end

  // Free-running core clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Compares one value and reports a mismatch.
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task stop_test;
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Lets two-stage status settle.
  task settle;
    repeat (3) @(negedge clk);
  endtask

  // Walks all four battery pin pairs on one slot.
  task batt_codes(input int s);
    logic [1:0] e;
    io[s] = 1'b0;
    for (int i = 0; i < 4; i++) begin
      bt[s] = 2'(i);
      e = !bt[s][0] ? 2'h2 : (!bt[s][1] ? 2'h1 : 2'h0);
      settle();
      chk(ba[s], e);
    end
  endtask

  // Status change and DMA request sources in and out of I/O mode.
  task status_lines(input int s);
    io[s] = 1'b1;
    bt[s] = 2'b10;
    settle();
    chk({sc[s], dq[s]}, 2'b10);
    bt[s] = 2'b01;
    settle();
    chk({sc[s], dq[s]}, 2'b01);
    io[s] = 1'b0;
    settle();
    chk(dq[s], 1'b0);
    rq[s] = 1'b1;
    settle();
    chk(dq[s], 1'b1);
    rq[s] = 1'b0;
    bt[s] = 2'b11;
  endtask

  // Both slots' audio bits merged onto one pin.
  task audio_merge;
    io = 2'b11;
    for (int i = 0; i < 4; i++) begin
      bt[0] = {i[0], 1'b1};
      bt[1] = {i[1], 1'b1};
      repeat (5) @(negedge clk);
      chk(au, i[0] ^ i[1]);
    end
    bt[0] = 2'b11;
    bt[1] = 2'b11;
    io = 2'b00;
  endtask

  // Starts refused with no card and with kind none.
  task refusals(input int s);
    ins[s] = 1'b0;
    settle();
    chk(pr[s], 1'b0);
    st[s] = 1'b1;
    kd[s] = 3'h1;
    repeat (6) @(negedge clk);
    chk(bz[s], 1'b0);
    st[s] = 1'b0;
    ins[s] = 1'b1;
    settle();
    chk(pr[s], 1'b1);
    st[s] = 1'b1;
    kd[s] = 3'h0;
    repeat (6) @(negedge clk);
    chk(bz[s], 1'b0);
    st[s] = 1'b0;
  endtask

  // One full I/O or DMA cycle with strobe and select checks.
  task run_cycle(input int s, input logic [2:0] k, input logic o, w);
    int   n;
    logic rx, wx;
    rx = (k == 3'h1 || k == 3'h4);
    wx = (k == 3'h2 || k == 3'h3);
    {st[s], kd[s], od[s], wd[s]} = {1'b1, k, o, w};
    n = 0;
    while (bz[s] !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    st[s] = 1'b0;
    chk(8'(n), 8'h2);
    chk({ev[s], ob[s], dk[s]}, {!(w || !o), !(w || o), k < 3'h3});
    @(negedge clk);
    chk({rd[s], wr[s]}, {!rx, !wx});
    repeat (8) @(negedge clk);
    chk(ra[s], rx);
    n = 0;
    while (dn[s] !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n), 8'hd);
    chk({rd[s], wr[s], ev[s], ob[s], dk[s]}, 5'h1f);
    @(negedge clk);
  endtask

  // A write frozen by the clock enable keeps its strobe, then resumes.
  task freeze_cycle;
    int n;
    {st[0], kd[0], od[0], wd[0]} = {1'b1, 3'h2, 1'b0, 1'b0};
    repeat (3) @(negedge clk);
    st[0] = 1'b0;
    ce = 1'b0;
    repeat (30) @(negedge clk);
    chk({wr[0], bz[0], dn[0]}, 3'h2);
    ce = 1'b1;
    n = 0;
    while (dn[0] !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n), 8'h15);
    @(negedge clk);
  endtask

  // Watchdog at about fifteen times the expected run length.
  initial begin
    #20000;
    fails++;
    stop_test();
  end

  // Main sequence.
  initial begin
    fails = 0;
    compares = 0;
    rst_b = 1'b0;
    ce = 1'b1;
    {st, od, wd, io, rq} = 10'h000;
    ins = 2'b11;
    ae = 2'b11;
    kd[0] = 3'h0;
    kd[1] = 3'h0;
    bt[0] = 2'b11;
    bt[1] = 2'b11;
    repeat (8) @(negedge clk);
    chk({rd, wr, ev, ob, dk, bz}, 12'hffc);
    rst_b = 1'b1;
    settle();
    batt_codes(0);
    batt_codes(1);
    status_lines(0);
    status_lines(1);
    audio_merge();
    refusals(0);
    refusals(1);
    run_cycle(0, 3'h1, 1'b0, 1'b0);
    run_cycle(0, 3'h2, 1'b1, 1'b0);
    run_cycle(0, 3'h3, 1'b0, 1'b1);
    run_cycle(0, 3'h4, 1'b1, 1'b1);
    run_cycle(1, 3'h1, 1'b1, 1'b0);
    run_cycle(1, 3'h3, 1'b0, 1'b1);
    freeze_cycle();
    stop_test();
  end
endmodule

`default_nettype wire
